// File: eptl_field_map.sv
// splits one configuration memory word into masked register updates
`timescale 1ns/1ns
`default_nettype none
module eptl_field_map
(
   input wire eptl_pkg::eptl_word_kind_t kind,
   input wire logic [eptl_pkg::PORT_W-1:0] port,
   input wire logic [eptl_pkg::MEM_DW-1:0] word,
   output eptl_pkg::eptl_cfg_update_t upd
);
   always_comb
   begin
      upd = '0;
      unique case (kind)
         eptl_pkg::WK_REPLAY:
         begin
            upd.m_timer[eptl_pkg::RTO_DST +: eptl_pkg::RTO_W] = '1;
            upd.v_timer[eptl_pkg::RTO_DST +: eptl_pkg::RTO_W] =
               word[eptl_pkg::RTO_SRC +: eptl_pkg::RTO_W];
            upd.m_timer[eptl_pkg::RTO_EN_DST] = 1'b1;
            upd.v_timer[eptl_pkg::RTO_EN_DST] = word[eptl_pkg::RTO_EN_SRC];
            upd.m_link[eptl_pkg::TS_DST +: eptl_pkg::TS_W] = '1;
            upd.v_link[eptl_pkg::TS_DST +: eptl_pkg::TS_W] =
               word[eptl_pkg::TS_SRC +: eptl_pkg::TS_W];
         end
         eptl_pkg::WK_ACK:
         begin
            upd.m_timer[eptl_pkg::ACK_DST +: eptl_pkg::ACK_W] = '1;
            upd.v_timer[eptl_pkg::ACK_DST +: eptl_pkg::ACK_W] =
               word[eptl_pkg::ACK_SRC +: eptl_pkg::ACK_W];
            upd.m_timer[eptl_pkg::ACK_EN_DST] = 1'b1;
            upd.v_timer[eptl_pkg::ACK_EN_DST] = word[eptl_pkg::ACK_EN_SRC];
         end
         eptl_pkg::WK_CTRL:
         begin
            upd.m_link[eptl_pkg::VLC_DST +: eptl_pkg::VLC_W] = '1;
            upd.v_link[eptl_pkg::VLC_DST +: eptl_pkg::VLC_W] =
               word[eptl_pkg::VLC_SRC +: eptl_pkg::VLC_W];
            upd.m_link[eptl_pkg::PDIS_DST] = 1'b1;
            upd.v_link[eptl_pkg::PDIS_DST] = word[eptl_pkg::PDIS_SRC];
            upd.m_link[eptl_pkg::RSEL_DST] = 1'b1;
            upd.v_link[eptl_pkg::RSEL_DST] = word[eptl_pkg::RSEL_SRC];
            if (port >= eptl_pkg::PM_FIRST_PORT)
            begin
               upd.m_pm[eptl_pkg::PM_DST] = 1'b1;
               upd.v_pm[eptl_pkg::PM_DST] = word[eptl_pkg::PM_SRC];
            end
         end
         default:
         begin
            upd = '0;
         end
      endcase
   end
endmodule
`default_nettype wire

// File: eptl_loader.sv
// loader that copies per-port link settings from the configuration memory into config registers
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module eptl_loader
#(
   parameter int NUM_PORTS = eptl_pkg::NUM_PORTS
)
(
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic MEM_RD_REQ,
   output logic [eptl_pkg::MEM_AW-1:0] MEM_RD_ADDR,
   input wire logic MEM_RD_ACK,
   input wire logic [eptl_pkg::MEM_DW-1:0] MEM_RD_DATA,
   output logic LOAD_DONE,
   output logic [NUM_PORTS-1:0] PORT_DISABLE
);
   localparam int PW = eptl_pkg::PORT_W;
   localparam logic [PW-1:0] LAST_PORT = PW'(NUM_PORTS - 1);
   typedef enum logic [2:0] {LD_REQ = 3'b001, LD_APPLY = 3'b010, LD_IDLE = 3'b100} eptl_ld_state_t;
   typedef enum logic [2:0] {SEL_NONE, SEL_TIMER, SEL_LINK, SEL_PM, SEL_CTRL, SEL_STATUS}
      eptl_sel_t;
   eptl_ld_state_t state_reg, state_next;
   logic [PW-1:0] port_reg, port_next;
   eptl_pkg::eptl_word_kind_t kind_reg, kind_next;
   logic [eptl_pkg::MEM_DW-1:0] word_reg;
   logic [eptl_pkg::MEM_AW-1:0] mem_addr_reg;
   eptl_pkg::eptl_cfg_update_t upd;
   logic [31:0] cfg_timer_reg [NUM_PORTS];
   logic [31:0] cfg_link_reg [NUM_PORTS];
   logic [31:0] cfg_pm_reg [NUM_PORTS];
   logic [NUM_PORTS-1:0] port_dis_reg;
   logic mem_req_reg, done_reg, pend_reg, wr_reg, hreadyout_reg, hresp_reg;
   logic [2:0] size_reg;
   logic [31:0] addr_reg, hrdata_reg;
   logic take, complete, wr_ok, ld_busy, last_word, reload_start;
   eptl_sel_t bus_sel;
   logic [PW-1:0] bus_port;
   function automatic eptl_sel_t reg_sel(input logic [31:0] a);
      logic [PW-1:0] pg;
      logic [eptl_pkg::PAGE_LSB-1:0] ofs;
      pg = a[eptl_pkg::PAGE_LSB +: PW];
      ofs = a[eptl_pkg::PAGE_LSB-1:0];
      reg_sel = SEL_NONE;
      if ((a[31:eptl_pkg::ADDR_TOP] == '0) && (pg == eptl_pkg::GLOBAL_PAGE))
      begin
         reg_sel = (ofs == eptl_pkg::OFS_CTRL) ? SEL_CTRL :
            (ofs == eptl_pkg::OFS_STATUS) ? SEL_STATUS : SEL_NONE;
      end
      else if ((a[31:eptl_pkg::ADDR_TOP] == '0) && (pg <= LAST_PORT))
      begin
         reg_sel = (ofs == eptl_pkg::OFS_TIMER) ? SEL_TIMER : (ofs == eptl_pkg::OFS_LINK) ?
            SEL_LINK : (ofs == eptl_pkg::OFS_PM) ? SEL_PM : SEL_NONE;
      end
   endfunction
   // ******************************************************************
   // loader sequence
   // ******************************************************************
   assign ld_busy = (state_reg != LD_IDLE);
   assign last_word = (kind_reg == eptl_pkg::WK_CTRL) && (port_reg == LAST_PORT);
   assign reload_start = complete && wr_ok && (bus_sel == SEL_CTRL) &&
      HWDATA[eptl_pkg::CTRL_RELOAD_BIT];
   always_comb
   begin
      state_next = state_reg;
      port_next = port_reg;
      kind_next = kind_reg;
      unique case (state_reg)
         LD_REQ: state_next = MEM_RD_ACK ? LD_APPLY : LD_REQ;
         LD_APPLY:
         begin
            state_next = last_word ? LD_IDLE : LD_REQ;
            port_next = (port_reg == LAST_PORT) ? '0 : port_reg + PW'(1);
            if (port_reg == LAST_PORT)
            begin
               kind_next = (kind_reg == eptl_pkg::WK_REPLAY) ? eptl_pkg::WK_ACK :
                  (kind_reg == eptl_pkg::WK_ACK) ? eptl_pkg::WK_CTRL : eptl_pkg::WK_REPLAY;
            end
         end
         LD_IDLE: state_next = reload_start ? LD_REQ : LD_IDLE;
      endcase
   end
   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         state_reg <= LD_REQ;
         port_reg <= '0;
         kind_reg <= eptl_pkg::WK_REPLAY;
         mem_req_reg <= 1'b1;
         mem_addr_reg <= eptl_pkg::WORD_BASE_REPLAY;
         done_reg <= 1'b0;
         word_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         port_reg <= port_next;
         kind_reg <= kind_next;
         mem_req_reg <= (state_next == LD_REQ);
         mem_addr_reg <= eptl_pkg::word_addr(kind_next, port_next);
         done_reg <= (state_next == LD_IDLE);
         if ((state_reg == LD_REQ) && MEM_RD_ACK)
         begin
            word_reg <= MEM_RD_DATA;
         end
      end
   end
   eptl_field_map eptl_field_map_inst
   (.kind(kind_reg), .port(port_reg), .word(word_reg), .upd(upd));
   // ******************************************************************
   // configuration registers
   // ******************************************************************
   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         for (int i = 0; i < NUM_PORTS; i++)
         begin
            cfg_timer_reg[i] <= eptl_pkg::RST_TIMER;
            cfg_link_reg[i] <= eptl_pkg::RST_LINK;
            cfg_pm_reg[i] <= eptl_pkg::RST_PM;
         end
      end
      else if (state_reg == LD_APPLY)
      begin
         // only masked fields change, the rest keeps its value
         cfg_timer_reg[port_reg] <= (cfg_timer_reg[port_reg] & ~upd.m_timer) |
            (upd.v_timer & upd.m_timer);
         cfg_link_reg[port_reg] <= (cfg_link_reg[port_reg] & ~upd.m_link) |
            (upd.v_link & upd.m_link);
         cfg_pm_reg[port_reg] <= (cfg_pm_reg[port_reg] & ~upd.m_pm) | (upd.v_pm & upd.m_pm);
      end
      else if (complete && wr_ok)
      begin
         unique case (bus_sel)
            SEL_TIMER: cfg_timer_reg[bus_port] <= HWDATA;
            SEL_LINK: cfg_link_reg[bus_port] <= HWDATA;
            SEL_PM: cfg_pm_reg[bus_port] <= HWDATA & eptl_pkg::PM_WR_MASK;
            SEL_NONE, SEL_CTRL, SEL_STATUS:
            begin
            end
         endcase
      end
   end
   for (genvar p = 0; p < NUM_PORTS; p++)
   begin : g_pdis
      always_ff @(posedge SYS_CLK or negedge RSTN)
      begin
         if (!RSTN)
         begin
            port_dis_reg[p] <= 1'b0;
         end
         else
         begin
            port_dis_reg[p] <= cfg_link_reg[p][eptl_pkg::PDIS_DST];
         end
      end
   end
   // ******************************************************************
   // bus slave
   // ******************************************************************
   assign take = HSEL && HTRANS[1] && HREADY;
   assign complete = pend_reg && !ld_busy;
   assign wr_ok = wr_reg && (size_reg == eptl_pkg::HSIZE_WORD);
   assign bus_sel = reg_sel(addr_reg);
   assign bus_port = addr_reg[eptl_pkg::PAGE_LSB +: PW];
   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         pend_reg <= 1'b0;
         wr_reg <= 1'b0;
         size_reg <= '0;
         addr_reg <= '0;
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end
      else if (take)
      begin
         pend_reg <= 1'b1;
         wr_reg <= HWRITE;
         size_reg <= HSIZE;
         addr_reg <= HADDR;
         hreadyout_reg <= 1'b0;
      end
      else if (complete)
      begin
         pend_reg <= 1'b0;
         hreadyout_reg <= 1'b1;
      end
   end
   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         hrdata_reg <= '0;
      end
      else if (complete && !wr_reg)
      begin
         unique case (bus_sel)
            SEL_TIMER: hrdata_reg <= cfg_timer_reg[bus_port];
            SEL_LINK: hrdata_reg <= cfg_link_reg[bus_port];
            SEL_PM: hrdata_reg <= cfg_pm_reg[bus_port];
            SEL_STATUS: hrdata_reg <= 32'(done_reg) << eptl_pkg::STATUS_DONE_BIT;
            SEL_NONE, SEL_CTRL: hrdata_reg <= '0;
         endcase
      end
   end
   assign HRDATA = hrdata_reg;
   assign HREADYOUT = hreadyout_reg;
   assign HRESP = hresp_reg;
   assign MEM_RD_REQ = mem_req_reg;
   assign MEM_RD_ADDR = mem_addr_reg;
   assign LOAD_DONE = done_reg;
   assign PORT_DISABLE = port_dis_reg;
   // ******************************************************************
   // checks
   // ******************************************************************
   logic chk_valid_reg;
   logic [PW-1:0] chk_port_reg;
   eptl_pkg::eptl_word_kind_t chk_kind_reg;
   // check pipeline only, it settles during the reset cycles
   always_ff @(posedge SYS_CLK)
   begin
      chk_valid_reg <= (state_reg == LD_APPLY);
      chk_port_reg <= port_reg;
      chk_kind_reg <= kind_reg;
   end
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);
   a_rto_value: assert property (chk_valid_reg && chk_kind_reg == eptl_pkg::WK_REPLAY |->
      cfg_timer_reg[chk_port_reg][11:0] == word_reg[11:0])
      else $error("replay time-out field not loaded");
   a_rto_enable: assert property (chk_valid_reg && chk_kind_reg == eptl_pkg::WK_REPLAY |->
      cfg_timer_reg[chk_port_reg][12] == word_reg[12])
      else $error("replay enable not loaded");
   a_ts_counter: assert property (chk_valid_reg && chk_kind_reg == eptl_pkg::WK_REPLAY |->
      cfg_link_reg[chk_port_reg][25:24] == word_reg[14:13])
      else $error("training set counter not loaded");
   a_ack_latency: assert property (chk_valid_reg && chk_kind_reg == eptl_pkg::WK_ACK |->
      cfg_timer_reg[chk_port_reg][29:16] == word_reg[13:0])
      else $error("ack latency field not loaded");
   a_ack_enable: assert property (chk_valid_reg && chk_kind_reg == eptl_pkg::WK_ACK |->
      cfg_timer_reg[chk_port_reg][30] == word_reg[14])
      else $error("ack latency enable not loaded");
   a_ctrl_byte: assert property (chk_valid_reg && chk_kind_reg == eptl_pkg::WK_CTRL |->
      cfg_link_reg[chk_port_reg][23:16] == word_reg[7:0])
      else $error("vendor link control byte not loaded");
   a_port_disable: assert property (chk_valid_reg && chk_kind_reg == eptl_pkg::WK_CTRL |=>
      PORT_DISABLE[$past(chk_port_reg)] == $past(word_reg[12]))
      else $error("port disable not loaded");
   a_pm_cap: assert property (chk_valid_reg && chk_kind_reg == eptl_pkg::WK_CTRL &&
      chk_port_reg != 3'h0 |-> cfg_pm_reg[chk_port_reg][0] == word_reg[13])
      else $error("pm capability not loaded");
   a_pm_port0: assert property (chk_valid_reg && chk_kind_reg == eptl_pkg::WK_CTRL &&
      chk_port_reg == 3'h0 |-> $stable(cfg_pm_reg[0]))
      else $error("port 0 pm register changed");
   a_reset_sel: assert property (chk_valid_reg && chk_kind_reg == eptl_pkg::WK_CTRL |->
      cfg_link_reg[chk_port_reg][11] == word_reg[14])
      else $error("reset select not loaded");
   a_replay_addr: assert property (MEM_RD_REQ && kind_reg == eptl_pkg::WK_REPLAY |->
      MEM_RD_ADDR == eptl_pkg::WORD_BASE_REPLAY + {4'h0, port_reg, 1'b0})
      else $error("replay word address wrong");
   a_stall_load: assert property (pend_reg && ld_busy |-> !HREADYOUT ##1 !HREADYOUT)
      else $error("bus answered during load");
   a_keep_unmapped: assert property (chk_valid_reg && chk_kind_reg == eptl_pkg::WK_ACK &&
      chk_port_reg == 3'h0 |-> $stable(cfg_timer_reg[0][15:0]))
      else $error("ack word touched other bits");
   c_load_done: cover property ($rose(LOAD_DONE));
   c_stalled_read: cover property (pend_reg && ld_busy ##[1:200] HREADYOUT);
   c_reload: cover property (reload_start ##1 MEM_RD_REQ);
endmodule
`default_nettype wire

// File: eptl_loader_test.sv
// self-checking testbench of the per-port link settings loader
`timescale 1ns/1ns
`default_nettype none
module eptl_loader_test;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic mem_req;
   logic [7:0] mem_addr;
   logic mem_ack;
   logic [15:0] mem_data;
   logic load_done;
   logic [5:0] port_disable;
   logic [3:0] lag = 4'h0;
   logic [7:0] seen_q[$];
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] rd;
   always #10 sys_clk = ~sys_clk;
   eptl_loader #(.NUM_PORTS(6)) eptl_loader_inst (.SYS_CLK(sys_clk), .RSTN(rstn), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .MEM_RD_REQ(mem_req), .MEM_RD_ADDR(mem_addr), .MEM_RD_ACK(mem_ack),
      .MEM_RD_DATA(mem_data), .LOAD_DONE(load_done), .PORT_DISABLE(port_disable));
   eptl_mem_model eptl_mem_model_inst (.clk(sys_clk), .rst_n(rstn), .rd_req(mem_req),
      .rd_addr(mem_addr), .lag(lag), .rd_ack(mem_ack), .rd_data(mem_data));
   // ******************************************************************
   // common tasks
   // ******************************************************************
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= eptl_pkg::HSIZE_WORD;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1)
         @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1)
         @(posedge sys_clk);
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0000_0000);
   endtask
   always @(posedge sys_clk)
   begin
      cycles++;
      if (mem_req === 1'b1 && mem_ack === 1'b1)
         seen_q.push_back(mem_addr);
      if (cycles == 20000)
      begin
         n_mismatch++;
         complete_run();
      end
   end
   // ******************************************************************
   // scenarios
   // ******************************************************************
   task automatic t_stall();
      ahb(1'b0, 32'h0000_0604, 32'h0000_0000);
      check("status", rd, 32'h0000_0001);
      check("load_done", {31'h0, load_done}, 32'h0000_0001);
   endtask
   task automatic t_order();
      logic [7:0] e;
      check("word_count", 32'(seen_q.size()), 32'h0000_0012);
      for (int i = 0; i < 18; i++)
      begin
         e = 8'hD0 + 8'((i / 6) * 16) + 8'((i % 6) * 2);
         check("mem_addr", {24'h0, seen_q[i]}, {24'h0, e});
      end
      seen_q.delete();
   endtask
   task automatic t_regs(input int xp, input logic [31:0] xt);
      logic [15:0] r;
      logic [15:0] k;
      logic [15:0] c;
      logic [5:0] dis;
      for (int p = 0; p < 6; p++)
      begin
         r = eptl_img_pkg::img(eptl_pkg::WORD_BASE_REPLAY + 8'(2 * p));
         k = eptl_img_pkg::img(eptl_pkg::WORD_BASE_ACK + 8'(2 * p));
         c = eptl_img_pkg::img(eptl_pkg::WORD_BASE_CTRL + 8'(2 * p));
         dis[p] = c[12];
         ahb(1'b0, 32'(p * 256) + 32'h0000_0070, 32'h0000_0000);
         check("timer", rd, {1'b0, k[14:0], 3'h0, r[12:0]} | (p == xp ? xt : 32'h0));
         ahb(1'b0, 32'(p * 256) + 32'h0000_008C, 32'h0000_0000);
         check("link", rd, {6'h00, r[14:13], c[7:0], 4'h0, c[14], c[12], 10'h000});
         ahb(1'b0, 32'(p * 256) + 32'h0000_009C, 32'h0000_0000);
         check("pm", rd, {31'h0, (p == 0) ? 1'b0 : c[13]});
      end
      check("port_disable", {26'h0, port_disable}, {26'h0, dis});
   endtask
   task automatic t_host();
      ahb(1'b1, 32'h0000_0270, 32'hFFFF_FFFF);
      ahb(1'b1, 32'h0000_019C, 32'hFFFF_FFFF);
      ahb(1'b0, 32'h0000_019C, 32'h0000_0000);
      check("pm_write", rd, 32'h0000_0001);
      ahb(1'b1, 32'h0000_0050, 32'hFFFF_FFFF);
      ahb(1'b0, 32'h0000_0050, 32'h0000_0000);
      check("unmapped", rd, 32'h0000_0000);
   endtask
   task automatic t_reload();
      lag <= 4'h3;
      ahb(1'b1, 32'h0000_0600, 32'h0000_0001);
      t_stall();
      t_order();
      t_regs(2, 32'h8000_E000);
   endtask
   initial
   begin
      repeat (8)
         @(posedge sys_clk);
      rstn <= 1'b1;
      t_stall();
      t_order();
      t_regs(-1, 32'h0000_0000);
      t_host();
      t_reload();
      complete_run();
   end
endmodule
`default_nettype wire

// File: eptl_mem_model.sv
// configuration memory image and a model of the memory that serves it
`timescale 1ns/1ns
`default_nettype none
package eptl_img_pkg;
   function automatic logic [15:0] img(input logic [7:0] a);
      logic [15:0] v;
      v = (16'(a) * 16'h2F1B + 16'h1357) & 16'h7FFF;
      if (a >= 8'hF0)
      begin
         v = v & 16'h70FF;
      end
      return v;
   endfunction
endpackage
module eptl_mem_model
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rd_req,
   input wire logic [7:0] rd_addr,
   input wire logic [3:0] lag,
   output logic rd_ack,
   output logic [15:0] rd_data
);
   logic [3:0] wait_reg;
   // one ack pulse per request after lag cycles; data toggles when not valid
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_reg <= 4'h0;
         rd_ack <= 1'b0;
         rd_data <= 16'hA5A5;
      end
      else if (rd_ack)
      begin
         rd_ack <= 1'b0;
         rd_data <= ~rd_data;
      end
      else if (rd_req && (wait_reg == lag))
      begin
         rd_ack <= 1'b1;
         rd_data <= eptl_img_pkg::img(rd_addr);
         wait_reg <= 4'h0;
      end
      else
      begin
         wait_reg <= rd_req ? wait_reg + 4'h1 : 4'h0;
         rd_data <= ~rd_data;
      end
   end
endmodule
`default_nettype wire

// File: eptl_pkg.sv
// constants, field layouts and carrier types for the per-port link settings loader
package eptl_pkg;
   // ******************************************************************
   // sizes
   // ******************************************************************
   localparam int NUM_PORTS = 6;
   localparam int PORT_W = 3;
   localparam int MEM_AW = 8;
   localparam int MEM_DW = 16;
   localparam int PAGE_LSB = 8;
   localparam int ADDR_TOP = PAGE_LSB + PORT_W;
   // ******************************************************************
   // configuration memory word addresses
   // ******************************************************************
   localparam logic [MEM_AW-1:0] WORD_BASE_REPLAY = 8'hD0;
   localparam logic [MEM_AW-1:0] WORD_BASE_ACK = 8'hE0;
   localparam logic [MEM_AW-1:0] WORD_BASE_CTRL = 8'hF0;
   localparam int WORD_STEP_SHIFT = 1;
   typedef enum logic [1:0] {WK_REPLAY = 2'h0, WK_ACK = 2'h1, WK_CTRL = 2'h2} eptl_word_kind_t;
   // ******************************************************************
   // register map
   // ******************************************************************
   localparam logic [PAGE_LSB-1:0] OFS_TIMER = 8'h70;
   localparam logic [PAGE_LSB-1:0] OFS_LINK = 8'h8C;
   localparam logic [PAGE_LSB-1:0] OFS_PM = 8'h9C;
   localparam logic [PAGE_LSB-1:0] OFS_CTRL = 8'h00;
   localparam logic [PAGE_LSB-1:0] OFS_STATUS = 8'h04;
   localparam logic [PORT_W-1:0] GLOBAL_PAGE = 3'h6;
   localparam int CTRL_RELOAD_BIT = 0;
   localparam int STATUS_DONE_BIT = 0;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [31:0] RST_TIMER = 32'h0000_0000;
   localparam logic [31:0] RST_LINK = 32'h0000_0000;
   localparam logic [31:0] RST_PM = 32'h0000_0000;
   localparam logic [31:0] PM_WR_MASK = 32'h0000_0001;
   // ******************************************************************
   // field positions: _SRC in the memory word, _DST in the register
   // ******************************************************************
   localparam int RTO_W = 12;
   localparam int RTO_SRC = 0;
   localparam int RTO_DST = 0;
   localparam int RTO_EN_SRC = 12;
   localparam int RTO_EN_DST = 12;
   localparam int TS_W = 2;
   localparam int TS_SRC = 13;
   localparam int TS_DST = 24;
   localparam int ACK_W = 14;
   localparam int ACK_SRC = 0;
   localparam int ACK_DST = 16;
   localparam int ACK_EN_SRC = 14;
   localparam int ACK_EN_DST = 30;
   localparam int VLC_W = 8;
   localparam int VLC_SRC = 0;
   localparam int VLC_DST = 16;
   localparam int PDIS_SRC = 12;
   localparam int PDIS_DST = 10;
   localparam int PM_SRC = 13;
   localparam int PM_DST = 0;
   localparam int RSEL_SRC = 14;
   localparam int RSEL_DST = 11;
   localparam logic [PORT_W-1:0] PM_FIRST_PORT = 3'h1;
   // ******************************************************************
   // carrier and helpers
   // ******************************************************************
   typedef struct packed {
      logic [31:0] m_timer;
      logic [31:0] v_timer;
      logic [31:0] m_link;
      logic [31:0] v_link;
      logic [31:0] m_pm;
      logic [31:0] v_pm;
   } eptl_cfg_update_t;
   function automatic logic [MEM_AW-1:0] word_addr(input eptl_word_kind_t kind,
                                                   input logic [PORT_W-1:0] port);
      logic [MEM_AW-1:0] base;
      base = (kind == WK_REPLAY) ? WORD_BASE_REPLAY : (kind == WK_ACK) ? WORD_BASE_ACK :
         WORD_BASE_CTRL;
      word_addr = base + (MEM_AW'(port) << WORD_STEP_SHIFT);
   endfunction
endpackage
